//--- hw/trace_port_pkg.sv
// Constants, register map and field layout of the trace port integration test block.
// Assumes a 32-bit APB register bus with a 12-bit byte address.
package trace_port_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_FIFO_ONE = 12'h000;
  localparam logic [11:0] OFF_OUT_DRIVE = 12'h004;
  localparam logic [11:0] OFF_FIFO_TWO = 12'h008;
  localparam logic [11:0] OFF_IN_READ = 12'h00c;
  localparam logic [11:0] OFF_MODE = 12'h010;
  localparam logic [11:0] OFF_CLAIM_SET = 12'h014;
  localparam logic [11:0] OFF_CLAIM_CLR = 12'h018;
  localparam logic [11:0] OFF_DEVCFG = 12'h01c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FIFO_VALID_TWO_BIT = 29;
  localparam int FIFO_CNT_TWO_LSB = 27;
  localparam int FIFO_VALID_ONE_BIT = 26;
  localparam int FIFO_CNT_ONE_LSB = 24;
  localparam int DRV_FLUSH_BIT = 1;
  localparam int DRV_READY_BIT = 0;
  localparam int IN_FLUSH_BIT = 1;
  localparam int IN_VALID_BIT = 0;
  localparam int DEV_NRZ_BIT = 11;
  localparam int DEV_MANC_BIT = 10;
  localparam int DEV_PAR_BIT = 9;
  localparam int DEV_FIFO_LSB = 6;
  localparam int DEV_INPUTS_LSB = 0;

  // ----------------------------------------------------------------
  // Fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] DEV_FIFO_FOUR = 3'h2;
  localparam logic [5:0] DEV_INPUTS_TWO = 6'h01;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] DRIVE_RESET = 2'h0;
  localparam logic [3:0] CLAIM_RESET = 4'h0;
  localparam logic [1:0] BYTES_PER_REG = 2'h3;

  // Operating modes selected by the mode field.
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_ITEST = 2'h1,
    MODE_IDATA = 2'h2,
    MODE_RSVD = 2'h3
  } mode_e;

endpackage

//--- hw/trace_port_integration_test.sv
// Integration test, claim tag and configuration logic of a trace port unit.
// Assumes an APB master on CLK and two byte-wide trace sources synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none

module trace_port_integration_test #(
  parameter logic [3:0] CLAIM_IMPL = 4'hf
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] TRACE_DATA_ONE,
  input wire logic TRACE_VALID_IN_ONE,
  output logic TRACE_READY_OUT_ONE,
  output logic FLUSH_VALID_OUT_ONE,
  input wire logic FLUSH_READY_IN_ONE,
  input wire logic [7:0] TRACE_DATA_TWO,
  input wire logic TRACE_VALID_IN_TWO,
  output logic TRACE_READY_OUT_TWO,
  output logic FLUSH_VALID_OUT_TWO,
  input wire logic FLUSH_READY_IN_TWO,
  input wire logic FUNC_READY_ONE,
  input wire logic FUNC_READY_TWO,
  input wire logic FUNC_FLUSH_VALID_ONE,
  input wire logic FUNC_FLUSH_VALID_TWO,
  output logic TRACE_OUTPUT_ENABLE
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // True for any address that holds a register.
  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == trace_port_pkg::OFF_FIFO_ONE) ||
                (addr == trace_port_pkg::OFF_OUT_DRIVE) ||
                (addr == trace_port_pkg::OFF_FIFO_TWO) ||
                (addr == trace_port_pkg::OFF_IN_READ) ||
                (addr == trace_port_pkg::OFF_MODE) ||
                (addr == trace_port_pkg::OFF_CLAIM_SET) ||
                (addr == trace_port_pkg::OFF_CLAIM_CLR) ||
                (addr == trace_port_pkg::OFF_DEVCFG);
  endfunction

  // True for the two data registers whose read has a side effect.
  function automatic logic is_fifo(input logic [11:0] addr);
    is_fifo = (addr == trace_port_pkg::OFF_FIFO_ONE) ||
              (addr == trace_port_pkg::OFF_FIFO_TWO);
  endfunction

  logic setup;
  logic access;
  logic wr_done;
  logic rd_done;
  logic fifo_stall;

  // Zero wait states: every access phase completes at its first edge.
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr_done = access & PWRITE & is_mapped(PADDR);
  assign rd_done = access & ~PWRITE;
  // Capture halts from setup to completion of a data register read, so the word
  // latched at setup is exactly what the read discards and no byte is lost.
  assign fifo_stall = PSEL & ~PWRITE & is_fifo(PADDR);
  assign PREADY = 1'b1;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  trace_port_pkg::mode_e mode_r;
  logic [1:0] drive_r;
  logic [3:0] claim_r;

  // Mode field; the reserved code is stored but acts as normal mode.
  // mode field store
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r <= trace_port_pkg::MODE_NORMAL;
    end else if (wr_done && PADDR == trace_port_pkg::OFF_MODE) begin
      mode_r <= trace_port_pkg::mode_e'(PWDATA[1:0]);
    end
  end

  // Output drive bits; they only reach the pins in integration test mode.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      drive_r <= trace_port_pkg::DRIVE_RESET;
    end else if (wr_done && PADDR == trace_port_pkg::OFF_OUT_DRIVE) begin
      drive_r <= PWDATA[1:0];
    end
  end

  // Claim tags; unimplemented tags can never be set.
  // set and clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      claim_r <= trace_port_pkg::CLAIM_RESET;
    end else if (wr_done && PADDR == trace_port_pkg::OFF_CLAIM_SET) begin
      claim_r <= claim_r | (PWDATA[3:0] & CLAIM_IMPL);
    end else if (wr_done && PADDR == trace_port_pkg::OFF_CLAIM_CLR) begin
      claim_r <= claim_r & ~PWDATA[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Trace input capture
  // ----------------------------------------------------------------
  logic [7:0] in_data [2];
  logic [1:0] in_valid;
  logic [1:0] in_flush_ready;
  logic [1:0] func_ready;
  logic [1:0] func_flush;
  logic [1:0] room;
  logic [1:0] accept;
  logic [1:0] discard;
  logic [1:0] cnt_r [2];
  logic [7:0] byte_r [2][3];
  logic [1:0] ready_out;
  logic [1:0] flush_out;

  assign in_data[0] = TRACE_DATA_ONE;
  assign in_data[1] = TRACE_DATA_TWO;
  assign in_valid = {TRACE_VALID_IN_TWO, TRACE_VALID_IN_ONE};
  assign in_flush_ready = {FLUSH_READY_IN_TWO, FLUSH_READY_IN_ONE};
  assign func_ready = {FUNC_READY_TWO, FUNC_READY_ONE};
  assign func_flush = {FUNC_FLUSH_VALID_TWO, FUNC_FLUSH_VALID_ONE};
  assign discard[0] = rd_done && PADDR == trace_port_pkg::OFF_FIFO_ONE;
  assign discard[1] = rd_done && PADDR == trace_port_pkg::OFF_FIFO_TWO;

  // One capture buffer of three bytes per interface, filled in arrival order.
  for (genvar gi = 0; gi < 2; gi++) begin : g_cap
    assign room[gi] = (mode_r == trace_port_pkg::MODE_IDATA) &&
                      (cnt_r[gi] < trace_port_pkg::BYTES_PER_REG) && !fifo_stall;
    assign accept[gi] = room[gi] & in_valid[gi];

    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        cnt_r[gi] <= 2'h0;
      end else if (discard[gi]) begin
        cnt_r[gi] <= 2'h0;
      end else if (accept[gi]) begin
        cnt_r[gi] <= cnt_r[gi] + 2'h1;
      end
    end

    // Bytes are held until the read; a stale byte above the count reads as zero.
    // byte storage
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        byte_r[gi][0] <= 8'h00;
        byte_r[gi][1] <= 8'h00;
        byte_r[gi][2] <= 8'h00;
      end else if (discard[gi]) begin
        byte_r[gi][0] <= 8'h00;
        byte_r[gi][1] <= 8'h00;
        byte_r[gi][2] <= 8'h00;
      end else if (accept[gi]) begin
        byte_r[gi][cnt_r[gi]] <= in_data[gi];
      end
    end

    // Handshake outputs chosen by mode; reserved mode behaves as normal.
    always_comb begin
      case (mode_r)
        trace_port_pkg::MODE_ITEST: begin
          ready_out[gi] = drive_r[trace_port_pkg::DRV_READY_BIT];
          flush_out[gi] = drive_r[trace_port_pkg::DRV_FLUSH_BIT];
        end
        trace_port_pkg::MODE_IDATA: begin
          ready_out[gi] = room[gi];
          flush_out[gi] = 1'b0;
        end
        default: begin
          ready_out[gi] = func_ready[gi];
          flush_out[gi] = func_flush[gi];
        end
      endcase
    end
  end

  assign TRACE_READY_OUT_ONE = ready_out[0];
  assign TRACE_READY_OUT_TWO = ready_out[1];
  assign FLUSH_VALID_OUT_ONE = flush_out[0];
  assign FLUSH_VALID_OUT_TWO = flush_out[1];
  assign TRACE_OUTPUT_ENABLE = (mode_r != trace_port_pkg::MODE_IDATA);

  // ----------------------------------------------------------------
  // Read mux and APB answer
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic [31:0] prdata_r;
  logic err_r;

  // Assemble the word for the current address; unmapped reads give zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (PADDR)
      trace_port_pkg::OFF_FIFO_ONE, trace_port_pkg::OFF_FIFO_TWO: begin
        rd_word[trace_port_pkg::FIFO_VALID_TWO_BIT] = TRACE_VALID_IN_TWO;
        rd_word[trace_port_pkg::FIFO_VALID_ONE_BIT] = TRACE_VALID_IN_ONE;
        rd_word[trace_port_pkg::FIFO_CNT_TWO_LSB +: 2] = cnt_r[1];
        rd_word[trace_port_pkg::FIFO_CNT_ONE_LSB +: 2] = cnt_r[0];
        if (PADDR == trace_port_pkg::OFF_FIFO_ONE) begin
          rd_word[23:0] = {byte_r[0][2], byte_r[0][1], byte_r[0][0]};
        end else begin
          rd_word[23:0] = {byte_r[1][2], byte_r[1][1], byte_r[1][0]};
        end
      end
      trace_port_pkg::OFF_OUT_DRIVE: rd_word[1:0] = drive_r;
      trace_port_pkg::OFF_IN_READ: begin
        rd_word[trace_port_pkg::IN_FLUSH_BIT] = |in_flush_ready;
        rd_word[trace_port_pkg::IN_VALID_BIT] = |in_valid;
      end
      trace_port_pkg::OFF_MODE: rd_word[1:0] = mode_r;
      trace_port_pkg::OFF_CLAIM_SET: rd_word[3:0] = CLAIM_IMPL;
      trace_port_pkg::OFF_CLAIM_CLR: rd_word[3:0] = claim_r;
      trace_port_pkg::OFF_DEVCFG: begin
        rd_word[trace_port_pkg::DEV_NRZ_BIT] = 1'b1;
        rd_word[trace_port_pkg::DEV_MANC_BIT] = 1'b1;
        rd_word[trace_port_pkg::DEV_PAR_BIT] = 1'b0;
        rd_word[trace_port_pkg::DEV_FIFO_LSB +: 3] = trace_port_pkg::DEV_FIFO_FOUR;
        rd_word[trace_port_pkg::DEV_INPUTS_LSB +: 6] = trace_port_pkg::DEV_INPUTS_TWO;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is latched at setup so the access phase drives it from flops.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= PWRITE ? 32'h0000_0000 : rd_word;
    end
  end

  // Unmapped addresses answer with an error in the access phase.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      err_r <= 1'b0;
    end else if (setup) begin
      err_r <= !is_mapped(PADDR);
    end
  end

  assign PRDATA = prdata_r;
  assign PSLVERR = err_r & access;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_fifo_one_setup;
    setup && !PWRITE && PADDR == trace_port_pkg::OFF_FIFO_ONE;
  endsequence

  sequence s_fifo_one_done;
    access && !PWRITE && PADDR == trace_port_pkg::OFF_FIFO_ONE;
  endsequence

  a_fifo_one_clear: assert property (
    s_fifo_one_setup ##1 s_fifo_one_done |=> cnt_r[0] == 2'h0 && byte_r[0][0] == 8'h00)
    else $error("port one bytes not discarded by read");

  a_fifo_one_data: assert property (
    s_fifo_one_setup ##1 s_fifo_one_done |->
      PRDATA[23:0] == {byte_r[0][2], byte_r[0][1], byte_r[0][0]})
    else $error("port one read data does not match held bytes");

  a_fifo_two_clear: assert property (
    discard[1] |=> cnt_r[1] == 2'h0 && byte_r[1][2] == 8'h00)
    else $error("port two bytes not discarded by read");

  a_count_step: assert property (
    accept[0] && !discard[0] |=> cnt_r[0] == $past(cnt_r[0]) + 2'h1)
    else $error("interface one count did not advance on capture");

  a_count_limit: assert property (
    cnt_r[1] == trace_port_pkg::BYTES_PER_REG |-> !TRACE_READY_OUT_TWO || mode_r != trace_port_pkg::MODE_IDATA)
    else $error("interface two ready with full buffer");

  a_valid_live: assert property (
    setup && !PWRITE && is_fifo(PADDR) ##1 access |->
      PRDATA[trace_port_pkg::FIFO_VALID_ONE_BIT] == $past(TRACE_VALID_IN_ONE) &&
      PRDATA[trace_port_pkg::FIFO_VALID_TWO_BIT] == $past(TRACE_VALID_IN_TWO) &&
      PRDATA[31:30] == 2'h0)
    else $error("valid bits in data register wrong");

  a_test_drive: assert property (
    mode_r == trace_port_pkg::MODE_ITEST |->
      TRACE_READY_OUT_ONE == drive_r[0] && TRACE_READY_OUT_TWO == drive_r[0] &&
      FLUSH_VALID_OUT_ONE == drive_r[1] && FLUSH_VALID_OUT_TWO == drive_r[1])
    else $error("test drive bits not on handshake outputs");

  a_normal_pass: assert property (
    mode_r == trace_port_pkg::MODE_NORMAL |->
      TRACE_READY_OUT_ONE == FUNC_READY_ONE && FLUSH_VALID_OUT_TWO == FUNC_FLUSH_VALID_TWO &&
      TRACE_READY_OUT_TWO == FUNC_READY_TWO && FLUSH_VALID_OUT_ONE == FUNC_FLUSH_VALID_ONE)
    else $error("normal mode outputs not from functional logic");

  a_data_mode_off: assert property (
    mode_r == trace_port_pkg::MODE_IDATA |-> !TRACE_OUTPUT_ENABLE && !FLUSH_VALID_OUT_ONE)
    else $error("trace output active in data test mode");

  a_in_or: assert property (
    setup && !PWRITE && PADDR == trace_port_pkg::OFF_IN_READ |=>
      PRDATA[1:0] == {$past(FLUSH_READY_IN_ONE | FLUSH_READY_IN_TWO),
                      $past(TRACE_VALID_IN_ONE | TRACE_VALID_IN_TWO)})
    else $error("input test read is not the OR of inputs");

  a_claim_set: assert property (
    wr_done && PADDR == trace_port_pkg::OFF_CLAIM_SET |=>
      claim_r == ($past(claim_r) | ($past(PWDATA[3:0]) & CLAIM_IMPL)))
    else $error("claim set write wrong");

  a_claim_clr: assert property (
    wr_done && PADDR == trace_port_pkg::OFF_CLAIM_CLR |=>
      claim_r == ($past(claim_r) & ~$past(PWDATA[3:0])))
    else $error("claim clear write wrong");

  a_devcfg_word: assert property (
    setup && !PWRITE && PADDR == trace_port_pkg::OFF_DEVCFG |=> PRDATA == 32'h0000_0c81)
    else $error("configuration word wrong");

endmodule

`default_nettype wire

//--- test/trace_source_model.sv
// Behavioural model of one trace byte source that faces the trace port block.
// Assumes the block's ready and flush outputs and bench send calls, all on one clock.
`timescale 1ns/1ps
`default_nettype none

module trace_source_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ready,
  input wire logic flush_valid,
  output logic [7:0] data,
  output logic valid,
  output logic flush_ready
);
  logic [7:0] byte_q[$];

  // Queues one byte; it is offered from the next clock edge on.
  task automatic send(input logic [7:0] b);
    byte_q.push_back(b);
  endtask

  // A byte stays offered until ready is seen high at an edge. While idle the data
  // lines toggle, so a stale byte can never pass for a fresh one.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data <= 8'h00;
      valid <= 1'b0;
    end else begin
      if (valid && ready) begin
        byte_q.delete(0);
      end
      if (byte_q.size() != 0) begin
        data <= byte_q[0];
        valid <= 1'b1;
      end else begin
        data <= ~data;
        valid <= 1'b0;
      end
    end
  end

  // A flush request is answered one cycle later and withdrawn with it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_ready <= 1'b0;
    end else begin
      flush_ready <= flush_valid;
    end
  end
endmodule

`default_nettype wire

//--- test/trace_port_integration_test_tb_top.sv
// Self-checking bench for the trace port integration test block.
// Assumes the block's package and the trace source model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module trace_port_integration_test_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] func_r = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, oe;
  logic [7:0] data_one, data_two;
  logic valid_one, valid_two, ready_one, ready_two, fv_one, fv_two, fr_one, fr_two;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'h0000000c;
  logic [7:0] b[8];
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  // The clock runs at 50 MHz.
  always #10 clk = ~clk;

  trace_port_integration_test dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TRACE_DATA_ONE(data_one),
    .TRACE_VALID_IN_ONE(valid_one), .TRACE_READY_OUT_ONE(ready_one),
    .FLUSH_VALID_OUT_ONE(fv_one), .FLUSH_READY_IN_ONE(fr_one), .TRACE_DATA_TWO(data_two),
    .TRACE_VALID_IN_TWO(valid_two), .TRACE_READY_OUT_TWO(ready_two),
    .FLUSH_VALID_OUT_TWO(fv_two), .FLUSH_READY_IN_TWO(fr_two), .FUNC_READY_ONE(func_r[0]),
    .FUNC_READY_TWO(func_r[1]), .FUNC_FLUSH_VALID_ONE(func_r[2]),
    .FUNC_FLUSH_VALID_TWO(func_r[3]), .TRACE_OUTPUT_ENABLE(oe));
  trace_source_model src_one (.clk(clk), .rst_n(reset_n), .ready(ready_one),
    .flush_valid(fv_one), .data(data_one), .valid(valid_one), .flush_ready(fr_one));
  trace_source_model src_two (.clk(clk), .rst_n(reset_n), .ready(ready_two),
    .flush_valid(fv_two), .data(data_two), .valid(valid_two), .flush_ready(fr_two));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Outputs are looked at 1 ns after the edge, once that edge's updates have landed.
  task automatic outs(input logic [4:0] e);
    #1;
    check({28'h0, oe, fv_two, fv_one, ready_two, ready_one}, {28'h0, e});
    @(posedge clk);
  endtask

  task automatic func_step(input logic [31:0] r);
    func_r <= r[3:0];
    @(posedge clk);
    outs({1'b1, r[3:0]});
  endtask

  // Each completed read takes the oldest note off the queue: {error, data}.
  always @(posedge clk) begin
    if (reset_n && psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(trace_port_pkg::OFF_MODE, 33'h0);
    rd(trace_port_pkg::OFF_OUT_DRIVE, 33'h0);
    rd(trace_port_pkg::OFF_CLAIM_CLR, 33'h0);
    rd(trace_port_pkg::OFF_CLAIM_SET, 33'hf);
    wr(trace_port_pkg::OFF_DEVCFG, 32'hffffffff);
    rd(trace_port_pkg::OFF_DEVCFG, {21'h0, 1'b1, 1'b1, 1'b0, 3'h2, 6'h01});
    rd(12'h020, 33'h100000000);
    // Drive bits set in normal mode must not reach the outputs.
    wr(trace_port_pkg::OFF_OUT_DRIVE, 32'h3);
    repeat (4) func_step(rnd());
    wr(trace_port_pkg::OFF_MODE, 32'h1);
    for (int d = 0; d < 4; d++) begin
      func_r <= ~{d[1], d[1], d[0], d[0]};
      wr(trace_port_pkg::OFF_OUT_DRIVE, 32'(d));
      outs({1'b1, d[1], d[1], d[0], d[0]});
      rd(trace_port_pkg::OFF_OUT_DRIVE, 33'(d));
    end
    // A stalled byte keeps valid up; flush ready follows flush valid.
    wr(trace_port_pkg::OFF_OUT_DRIVE, 32'h0);
    src_one.send(8'h5a);
    repeat (2) @(posedge clk);
    rd(trace_port_pkg::OFF_IN_READ, 33'h1);
    wr(trace_port_pkg::OFF_OUT_DRIVE, 32'h2);
    rd(trace_port_pkg::OFF_IN_READ, 33'h3);
    wr(trace_port_pkg::OFF_OUT_DRIVE, 32'h1);
    rd(trace_port_pkg::OFF_IN_READ, 33'h0);
    wr(trace_port_pkg::OFF_MODE, 32'h3);
    rd(trace_port_pkg::OFF_MODE, 33'h3);
    func_step(rnd());
    wr(trace_port_pkg::OFF_MODE, 32'h2);
    outs(5'b00011);
    // Four bytes on each source: both buffers fill and each fourth byte stalls
    // with its valid high, so both live valid bits read as one.
    for (int i = 0; i < 8; i++) begin
      b[i] = 8'(rnd());
      if (i < 4) src_one.send(b[i]);
      else src_two.send(b[i]);
    end
    repeat (8) @(posedge clk);
    rd(trace_port_pkg::OFF_FIFO_ONE,
       {3'h0, 1'b1, 2'd3, 1'b1, 2'd3, b[2], b[1], b[0]});
    repeat (3) @(posedge clk);
    rd(trace_port_pkg::OFF_FIFO_TWO,
       {3'h0, 1'b1, 2'd3, 1'b0, 2'd1, b[6], b[5], b[4]});
    repeat (3) @(posedge clk);
    rd(trace_port_pkg::OFF_FIFO_ONE,
       {3'h0, 1'b0, 2'd1, 1'b0, 2'd1, 16'h0, b[3]});
    // Claim tags: set, no-effect zero, clear and reserved upper bits.
    wr(trace_port_pkg::OFF_CLAIM_SET, 32'h5);
    wr(trace_port_pkg::OFF_CLAIM_SET, 32'h0);
    rd(trace_port_pkg::OFF_CLAIM_CLR, 33'h5);
    wr(trace_port_pkg::OFF_CLAIM_CLR, 32'h4);
    rd(trace_port_pkg::OFF_CLAIM_CLR, 33'h1);
    rd(trace_port_pkg::OFF_CLAIM_SET, 33'hf);
    wr(trace_port_pkg::OFF_CLAIM_SET, 32'hfffffffa);
    rd(trace_port_pkg::OFF_CLAIM_CLR, 33'hb);
    wr(trace_port_pkg::OFF_MODE, 32'h0);
    func_step(rnd());
    // A reset in mid-run must return the drive bits and claim tags to zero.
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(trace_port_pkg::OFF_OUT_DRIVE, 33'h0);
    rd(trace_port_pkg::OFF_CLAIM_CLR, 33'h0);
    repeat (2) @(posedge clk);
    if (exp_q.size() != 0) miscompares++;
    print_verdict();
  end
endmodule

`default_nettype wire
